// ===== core/pin_sync.sv
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins in and synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] sync_q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

endmodule : pin_sync

// ===== core/tdm_link_port.sv
// Added by the designer: the AXI4-Lite slave port.
module tdm_link_port (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // AXI4-Lite write address
    input wire logic [tdm_pkg::AXI_AW-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read address
    input wire logic [tdm_pkg::AXI_AW-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // AXI4-Lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Transmit link pins
    input wire logic [tdm_pkg::LINKS-1:0] TRANSMIT_BIT_CLOCK,
    input wire logic [tdm_pkg::LINKS-1:0] TRANSMIT_FRAME_PULSE_IN,
    output logic [tdm_pkg::LINKS-1:0] TRANSMIT_FRAME_PULSE_OUT,
    output logic [tdm_pkg::LINKS-1:0] TRANSMIT_FRAME_PULSE_OE_N,
    output logic [tdm_pkg::LINKS-1:0] TXD,
    output logic [tdm_pkg::LINKS-1:0] TXD_OE_N,
    // Receive link pins
    input wire logic [tdm_pkg::LINKS-1:0] RXCK,
    input wire logic [tdm_pkg::LINKS-1:0] RXSYNC,
    input wire logic [tdm_pkg::LINKS-1:0] RXD,
    // Cell side transmit bytes
    input wire logic [8*tdm_pkg::LINKS-1:0] TX_BYTE,
    output logic [tdm_pkg::LINKS-1:0] TX_BYTE_TAKEN,
    // Cell side receive bytes
    output logic [8*tdm_pkg::LINKS-1:0] RX_BYTE,
    output logic [tdm_pkg::LINKS-1:0] RX_BYTE_VALID
);

    localparam int N = tdm_pkg::LINKS;

    // Registers
    logic [N-1:0][15:0] tx_ctrl_q;
    logic [N-1:0][15:0] rx_ctrl_q;
    logic [2*N-1:0][15:0] tx_map_q;
    logic [2*N-1:0][15:0] rx_map_q;

    // Bus slave state
    logic aw_held_q;
    logic w_held_q;
    logic [tdm_pkg::AXI_AW-1:0] awaddr_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_data;

    // Link state
    logic [5*N-1:0] pins_s;
    logic [N-1:0] tck_prev_q;
    logic [N-1:0] rck_prev_q;
    logic [N-1:0] tx_run;
    logic [N-1:0] rx_run;
    logic [N-1:0] tx_lock;
    logic [N-1:0] rx_lock;
    logic [N-1:0] tx_ev;
    logic [N-1:0] rx_ev;
    logic [N-1:0][1:0] tx_own_q;
    logic [N-1:0][1:0] rx_own_q;
    logic [N-1:0][7:0] rx_eng_byte;
    logic [N-1:0] tx_byte_tk;
    logic [N-1:0] rx_valid_d;
    logic [N-1:0][7:0] rx_byte_d;
    logic [N-1:0][2:0] tx_look;
    logic [N-1:0][2:0] rx_look;

    // Owner and enable of one slot of a leader's stream
    function automatic logic [2:0] slot_owner(
        input logic [2*N-1:0][15:0] maps,
        input logic [N-1:0][15:0] ctrls,
        input int lead,
        input tdm_pkg::group_e g,
        input logic [6:0] s
    );
        logic [2:0] r;
        int k;
        int m;
        r = 3'h0;
        k = tdm_pkg::group_size(g);
        if (g == tdm_pkg::G_MUX2 || g == tdm_pkg::G_MUX4)
        begin
            m = lead + int'(s) % k;
            if (m < N)
                r = {maps[2*m + int'(s) / k / 16][int'(s) / k % 16], 2'(m)};
        end
        else if (g == tdm_pkg::G_SINGLE)
            r = {maps[2*lead + int'(s[4])][s[3:0]], 2'(lead)};
        else
        begin
            for (int j = 3; j >= 0; j--)
            begin
                if (j < k && lead + j < N)
                begin
                    if (ctrls[lead+j][tdm_pkg::EN_BIT] && maps[2*(lead+j) + int'(s[4])][s[3:0]])
                        r = {1'b1, 2'(lead + j)};
                end
            end
        end
        return r;
    endfunction : slot_owner

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d, input logic [1:0] st);
        return {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // AXI4-Lite handshake
    wire aw_take = AWVALID && AWREADY;
    wire w_take = WVALID && WREADY;
    wire do_write = aw_held_q && w_held_q && !BVALID;
    wire ar_take = ARVALID && ARREADY;
    wire [11:0] widx = awaddr_q[13:2];
    wire [11:0] ridx = ARADDR[13:2];

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= tdm_pkg::RESP_OKAY;
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= tdm_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= AWADDR;
                AWREADY <= 1'b0;
            end
            else if (do_write)
            begin
                aw_held_q <= 1'b0;
                AWREADY <= 1'b1;
            end
            if (w_take)
            begin
                w_held_q <= 1'b1;
                wdata_q <= WDATA[15:0];
                wstrb_q <= WSTRB[1:0];
                WREADY <= 1'b0;
            end
            else if (do_write)
            begin
                w_held_q <= 1'b0;
                WREADY <= 1'b1;
            end
            if (do_write)
            begin
                BVALID <= 1'b1;
                BRESP <= wr_hit ? tdm_pkg::RESP_OKAY : tdm_pkg::RESP_SLVERR;
            end
            else if (BREADY)
                BVALID <= 1'b0;
            if (ar_take)
            begin
                ARREADY <= 1'b0;
                RVALID <= 1'b1;
                RDATA <= rd_data;
                RRESP <= rd_hit ? tdm_pkg::RESP_OKAY : tdm_pkg::RESP_SLVERR;
            end
            else if (RVALID && RREADY)
            begin
                RVALID <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end

    // Address decode
    always_comb
    begin
        wr_hit = 1'b0;
        rd_hit = (ridx == tdm_pkg::STATUS_IDX);
        rd_data = rd_hit ? {16'h0000, rx_run, tx_run, rx_lock, tx_lock} : 32'h00000000;
        for (int k = 0; k < N; k++)
        begin
            if (widx == tdm_pkg::TX_CTRL_IDX + 12'(k) || widx == tdm_pkg::RX_CTRL_IDX + 12'(k))
                wr_hit = 1'b1;
            if (ridx == tdm_pkg::TX_CTRL_IDX + 12'(k))
            begin
                rd_hit = 1'b1;
                rd_data = {16'h0000, tx_ctrl_q[k]};
            end
            if (ridx == tdm_pkg::RX_CTRL_IDX + 12'(k))
            begin
                rd_hit = 1'b1;
                rd_data = {16'h0000, rx_ctrl_q[k]};
            end
        end
        for (int k = 0; k < 2 * N; k++)
        begin
            if (widx == tdm_pkg::TX_MAP_IDX + 12'(k) || widx == tdm_pkg::RX_MAP_IDX + 12'(k))
                wr_hit = 1'b1;
            if (ridx == tdm_pkg::TX_MAP_IDX + 12'(k))
            begin
                rd_hit = 1'b1;
                rd_data = {16'h0000, tx_map_q[k]};
            end
            if (ridx == tdm_pkg::RX_MAP_IDX + 12'(k))
            begin
                rd_hit = 1'b1;
                rd_data = {16'h0000, rx_map_q[k]};
            end
        end
    end

    // Control and mapping registers
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            tx_ctrl_q <= {N{tdm_pkg::CTRL_RST}};
            rx_ctrl_q <= {N{tdm_pkg::CTRL_RST}};
            tx_map_q <= {2*N{tdm_pkg::MAP_RST}};
            rx_map_q <= {2*N{tdm_pkg::MAP_RST}};
        end
        else if (do_write)
        begin
            for (int k = 0; k < N; k++)
            begin
                if (widx == tdm_pkg::TX_CTRL_IDX + 12'(k))
                    tx_ctrl_q[k] <= merge16(tx_ctrl_q[k], wdata_q, wstrb_q);
                if (widx == tdm_pkg::RX_CTRL_IDX + 12'(k))
                    rx_ctrl_q[k] <= merge16(rx_ctrl_q[k], wdata_q, wstrb_q);
            end
            for (int k = 0; k < 2 * N; k++)
            begin
                if (widx == tdm_pkg::TX_MAP_IDX + 12'(k))
                    tx_map_q[k] <= merge16(tx_map_q[k], wdata_q, wstrb_q);
                if (widx == tdm_pkg::RX_MAP_IDX + 12'(k))
                    rx_map_q[k] <= merge16(rx_map_q[k], wdata_q, wstrb_q);
            end
        end
    end

    // Pin synchronisers
    pin_sync #(
        .W(5 * N)
    ) u_pins (
        .clk(CLK),
        .rst(RESET),
        .d({RXD, RXSYNC, RXCK, TRANSMIT_FRAME_PULSE_IN, TRANSMIT_BIT_CLOCK}),
        .sync_q(pins_s)
    );

    wire [N-1:0] tck_s = pins_s[N-1:0];
    wire [N-1:0] tsync_s = pins_s[2*N-1:N];
    wire [N-1:0] rck_s = pins_s[3*N-1:2*N];
    wire [N-1:0] rsync_s = pins_s[4*N-1:3*N];
    wire [N-1:0] rxd_s = pins_s[5*N-1:4*N];

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            tck_prev_q <= '0;
            rck_prev_q <= '0;
            tx_own_q <= '0;
            rx_own_q <= '0;
            TRANSMIT_FRAME_PULSE_OE_N <= '1;
            TX_BYTE_TAKEN <= '0;
            RX_BYTE_VALID <= '0;
            RX_BYTE <= '0;
        end
        else
        begin
            tck_prev_q <= tck_s;
            rck_prev_q <= rck_s;
            for (int k = 0; k < N; k++)
                TRANSMIT_FRAME_PULSE_OE_N[k] <= !(tx_run[k] && !tx_ctrl_q[k][tdm_pkg::TX_CLK_IN_BIT]);
            TX_BYTE_TAKEN <= tx_byte_tk;
            RX_BYTE_VALID <= rx_valid_d;
            RX_BYTE <= rx_byte_d;
            for (int k = 0; k < N; k++)
            begin
                tx_own_q[k] <= tx_look[k][1:0];
                rx_own_q[k] <= rx_look[k][1:0];
            end
        end
    end

    // Per link engines, one per direction

    for (genvar i = 0; i < N; i++)
    begin : g_link
        wire tdm_pkg::group_e tx_g = tdm_pkg::decode_group(tx_ctrl_q[i], 1'b0);
        wire tdm_pkg::group_e rx_g = tdm_pkg::decode_group(rx_ctrl_q[i], 1'b1);
        wire [6:0] tx_slot;
        wire [6:0] rx_slot;
        wire tx_t1 = (tx_ctrl_q[i][tdm_pkg::RATE_LSB+:2] == tdm_pkg::RATE_T1);
        wire rx_t1 = (rx_ctrl_q[i][tdm_pkg::RATE_LSB+:2] == tdm_pkg::RATE_T1);
        wire tx_dbl = tx_ctrl_q[i][tdm_pkg::FMT_BIT] && !tx_t1;
        wire rx_dbl = rx_ctrl_q[i][tdm_pkg::FMT_BIT] && !rx_t1;
        assign tx_run[i] = (tx_g != tdm_pkg::G_OFF) && (i % tdm_pkg::group_size(tx_g) == 0);
        assign rx_run[i] = (rx_g != tdm_pkg::G_OFF) && (i % tdm_pkg::group_size(rx_g) == 0);
        assign tx_look[i] = slot_owner(tx_map_q, tx_ctrl_q, i, tx_g, tx_slot);
        assign rx_look[i] = slot_owner(rx_map_q, rx_ctrl_q, i, rx_g, rx_slot);

        tdm_slot_engine #(
            .IS_TX(1'b1)
        ) u_tx (
            .clk(CLK),
            .rst(RESET),
            .ck_rise(tck_s[i] && !tck_prev_q[i]),
            .ck_fall(!tck_s[i] && tck_prev_q[i]),
            .sync_lvl(tsync_s[i]),
            .rxd_lvl(1'b0),
            .run(tx_run[i]),
            .t1(tx_t1),
            .dbl(tx_dbl),
            .sync_in(tx_ctrl_q[i][tdm_pkg::TX_CLK_IN_BIT]),
            .sync_hi(tx_ctrl_q[i][tdm_pkg::SYNC_HI_BIT]),
            .len_m1(tdm_pkg::frame_len_m1(tx_g, tx_ctrl_q[i])),
            .look_slot(tx_slot),
            .slot_en(tx_look[i][2]),
            .tx_byte(TX_BYTE[{tx_look[i][1:0], 3'h0}+:8]),
            .ev_q(tx_ev[i]),
            .rx_byte_q(),
            .txd_q(TXD[i]),
            .txd_oe_n_q(TXD_OE_N[i]),
            .sync_out_q(TRANSMIT_FRAME_PULSE_OUT[i]),
            .locked_q(tx_lock[i])
        );

        tdm_slot_engine #(
            .IS_TX(1'b0)
        ) u_rx (
            .clk(CLK),
            .rst(RESET),
            .ck_rise(rck_s[i] && !rck_prev_q[i]),
            .ck_fall(!rck_s[i] && rck_prev_q[i]),
            .sync_lvl(rsync_s[i]),
            .rxd_lvl(rxd_s[i]),
            .run(rx_run[i]),
            .t1(rx_t1),
            .dbl(rx_dbl),
            .sync_in(1'b1),
            .sync_hi(rx_ctrl_q[i][tdm_pkg::SYNC_HI_BIT]),
            .len_m1(tdm_pkg::frame_len_m1(rx_g, rx_ctrl_q[i])),
            .look_slot(rx_slot),
            .slot_en(rx_look[i][2]),
            .tx_byte(8'h00),
            .ev_q(rx_ev[i]),
            .rx_byte_q(rx_eng_byte[i]),
            .txd_q(),
            .txd_oe_n_q(),
            .sync_out_q(),
            .locked_q(rx_lock[i])
        );
    end

    // Route byte events to their owning link
    always_comb
    begin
        tx_byte_tk = '0;
        rx_valid_d = '0;
        rx_byte_d = RX_BYTE;
        for (int j = 0; j < N; j++)
        begin
            for (int e = 0; e < N; e++)
            begin
                if (tx_ev[e] && tx_own_q[e] == 2'(j))
                    tx_byte_tk[j] = 1'b1;
                if (rx_ev[e] && rx_own_q[e] == 2'(j))
                begin
                    rx_valid_d[j] = 1'b1;
                    rx_byte_d[j] = rx_eng_byte[e];
                end
            end
        end
    end

endmodule : tdm_link_port

// ===== core/tdm_pkg.sv
package tdm_pkg;

    // Link count and register bus address width
    localparam int LINKS = 4;
    localparam int AXI_AW = 14;

    // Register indices, byte address is four times the index
    localparam logic [11:0] TX_CTRL_IDX = 12'h600;
    localparam logic [11:0] RX_CTRL_IDX = 12'h700;
    localparam logic [11:0] TX_MAP_IDX = 12'h610;
    localparam logic [11:0] RX_MAP_IDX = 12'h710;
    localparam logic [11:0] STATUS_IDX = 12'h720;

    // Link control field positions
    localparam int SYNC_HI_BIT = 0;
    localparam int FMT_BIT = 2;
    localparam int MUX_LSB = 3;
    localparam int RATE_LSB = 5;
    localparam int EN_BIT = 7;
    localparam int TX_CLK_IN_BIT = 9;
    localparam int DELIN_BIT = 10;

    // Field encodings
    localparam logic [1:0] RATE_T1 = 2'h0;
    localparam logic [1:0] RATE_E1 = 2'h1;
    localparam logic [1:0] RATE_MUX2 = 2'h2;
    localparam logic [1:0] RATE_MUX4 = 2'h3;
    localparam logic [1:0] MUX_NONE = 2'h0;
    localparam logic [1:0] MUX_PAIR = 2'h1;
    localparam logic [1:0] MUX_QUAD = 2'h2;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] MAP_RST = 16'h0000;

    // Frame lengths in bits, minus one
    localparam logic [9:0] LEN_T1_M1 = 10'h0C0;
    localparam logic [9:0] LEN_E1_M1 = 10'h0FF;
    localparam logic [9:0] LEN_MUX2_M1 = 10'h1FF;
    localparam logic [9:0] LEN_MUX4_M1 = 10'h3FF;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        G_OFF = 3'h0,
        G_SINGLE = 3'h1,
        G_WOR2 = 3'h3,
        G_WOR4 = 3'h2,
        G_MUX2 = 3'h6,
        G_MUX4 = 3'h7
    } group_e;

    // Operating mode from a link control word
    function automatic group_e decode_group(input logic [15:0] c, input logic rx);
        logic [1:0] rate;
        logic [1:0] mux;
        logic fmt;
        logic clk_ok;
        group_e g;
        rate = c[RATE_LSB+:2];
        mux = c[MUX_LSB+:2];
        fmt = c[FMT_BIT];
        clk_ok = rx || c[TX_CLK_IN_BIT];
        g = G_OFF;
        if (c[EN_BIT] && !(rx && c[DELIN_BIT]))
        begin
            if (mux == MUX_NONE && ((rate == RATE_T1 && !fmt) || rate == RATE_E1))
                g = G_SINGLE;
            else if (mux == MUX_PAIR && (rate == RATE_T1 || rate == RATE_E1))
                g = G_WOR2;
            else if (mux == MUX_QUAD && (rate == RATE_T1 || rate == RATE_E1))
                g = G_WOR4;
            else if (mux == MUX_PAIR && rate == RATE_MUX2 && fmt && clk_ok)
                g = G_MUX2;
            else if (mux == MUX_QUAD && rate == RATE_MUX4 && fmt && clk_ok)
                g = G_MUX4;
        end
        return g;
    endfunction : decode_group

    function automatic int group_size(input group_e g);
        return (g == G_WOR2 || g == G_MUX2) ? 2 : ((g == G_WOR4 || g == G_MUX4) ? 4 : 1);
    endfunction : group_size

    function automatic logic [9:0] frame_len_m1(input group_e g, input logic [15:0] c);
        if (g == G_MUX2)
            return LEN_MUX2_M1;
        if (g == G_MUX4)
            return LEN_MUX4_M1;
        return (c[RATE_LSB+:2] == RATE_T1) ? LEN_T1_M1 : LEN_E1_M1;
    endfunction : frame_len_m1

endpackage : tdm_pkg

// ===== core/tdm_slot_engine.sv
module tdm_slot_engine #(
    parameter bit IS_TX = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link pins, already synchronised
    input wire logic ck_rise,
    input wire logic ck_fall,
    input wire logic sync_lvl,
    input wire logic rxd_lvl,
    // Configuration
    input wire logic run,
    input wire logic t1,
    input wire logic dbl,
    input wire logic sync_in,
    input wire logic sync_hi,
    input wire logic [9:0] len_m1,
    // Slot lookup
    output logic [6:0] look_slot,
    input wire logic slot_en,
    input wire logic [7:0] tx_byte,
    // Results
    output logic ev_q,
    output logic [7:0] rx_byte_q,
    output logic txd_q,
    output logic txd_oe_n_q,
    output logic sync_out_q,
    output logic locked_q
);

    logic [9:0] pos_q;
    logic [9:0] pos_d;
    logic phase_q;
    logic sync_prev_q;
    logic [7:0] sh_q;

    // Frame pulse edge, bit boundary and mid-bit sample
    wire sync_act = (sync_lvl == sync_hi);
    wire start = run && sync_in && ck_rise && sync_act && !sync_prev_q;
    wire tick = run && ck_rise && !start && (!dbl || !phase_q);
    wire smp = run && !start && (dbl ? (ck_rise && phase_q) : ck_fall);
    wire wrap = (pos_q >= len_m1);
    wire adv = start || tick;
    wire locked_now = locked_q || start || !sync_in;

    assign pos_d = start ? 10'h000 : (tick ? (wrap ? 10'h000 : pos_q + 10'h001) : pos_q);
    wire framing = t1 && (pos_d == 10'h000);
    wire [9:0] pidx = t1 ? pos_d - 10'h001 : pos_d;
    assign look_slot = pidx[9:3];
    wire [2:0] bit_in = pidx[2:0];
    wire carry = !framing && slot_en;

    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            pos_q <= 10'h000;
            phase_q <= 1'b0;
            sync_prev_q <= 1'b0;
            sh_q <= 8'h00;
            ev_q <= 1'b0;
            rx_byte_q <= 8'h00;
            txd_q <= 1'b0;
            txd_oe_n_q <= 1'b1;
            sync_out_q <= 1'b0;
            locked_q <= 1'b0;
        end
        else
        begin
            ev_q <= 1'b0;
            pos_q <= pos_d;
            if (ck_rise)
            begin
                sync_prev_q <= sync_act;
                phase_q <= start ? 1'b1 : (dbl && !phase_q);
            end
            if (start || !sync_in)
                locked_q <= 1'b1;
            if (IS_TX && adv)
            begin
                if (locked_now && carry)
                begin
                    txd_oe_n_q <= 1'b0;
                    if (bit_in == 3'h0)
                    begin
                        txd_q <= tx_byte[7];
                        sh_q <= {tx_byte[6:0], 1'b0};
                        ev_q <= 1'b1;
                    end
                    else
                    begin
                        txd_q <= sh_q[7];
                        sh_q <= {sh_q[6:0], 1'b0};
                    end
                end
                else
                    txd_oe_n_q <= 1'b1;
                sync_out_q <= (!sync_in && pos_d == 10'h000) ? sync_hi : !sync_hi;
            end
            if (!IS_TX && smp && locked_q && carry)
            begin
                sh_q <= {sh_q[6:0], rxd_lvl};
                if (bit_in == 3'h7)
                begin
                    rx_byte_q <= {sh_q[6:0], rxd_lvl};
                    ev_q <= 1'b1;
                end
            end
        end
    end

endmodule : tdm_slot_engine

// ===== testbench/tdm_framer_model.sv
module tdm_framer_model (
    // Frame length
    input wire logic [9:0] len,
    // Looped data
    input wire logic txd,
    input wire logic txd_oe_n,
    // Link pins
    output logic ck,
    output logic sync,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] n = 10'h000;
    initial
    begin
        ck = 1'b0;
        sync = 1'b0;
        rxd = 1'b0;
        forever #32 ck = ~ck;
    end
    always @(negedge ck)
    begin
        n <= (n >= len - 10'h001) ? 10'h000 : n + 10'h001;
        sync <= n >= len - 10'h001;
    end
    always @(posedge ck) #24 rxd = txd_oe_n ? ~rxd : txd;
endmodule : tdm_framer_model

// ===== testbench/tdm_link_port_assertions.sv
module tdm_link_port_assertions (
    // Clock, reset
    input wire logic CLK,
    input wire logic RESET,
    // Bus
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    // Link
    input wire logic [3:0] TXD_OE_N,
    input wire logic [3:0] TX_BYTE_TAKEN,
    input wire logic [3:0] RX_BYTE_VALID
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RESET);
    property p_wr; AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID; endproperty
    a_wr: assert property (p_wr) else $error("wr");
    property p_aw; AWVALID && AWREADY |=> !AWREADY; endproperty
    a_aw: assert property (p_aw) else $error("aw");
    property p_bh; BVALID && !BREADY |=> BVALID; endproperty
    a_bh: assert property (p_bh) else $error("bh");
    property p_rd; ARVALID && ARREADY |=> RVALID && !ARREADY; endproperty
    a_rd: assert property (p_rd) else $error("rd");
    property p_rh; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
    a_rh: assert property (p_rh) else $error("rh");
    property p_tk; TX_BYTE_TAKEN[0] |=> !TX_BYTE_TAKEN[0]; endproperty
    a_tk: assert property (p_tk) else $error("tk");
    property p_oe; TX_BYTE_TAKEN[0] |-> !TXD_OE_N[0]; endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_rv; RX_BYTE_VALID[0] |=> !RX_BYTE_VALID[0]; endproperty
    a_rv: assert property (p_rv) else $error("rv");
    c_wr: cover property (BVALID && BREADY);
    c_tk: cover property (TX_BYTE_TAKEN[0]);
    c_rv: cover property (RX_BYTE_VALID[0]);
endmodule : tdm_link_port_assertions
bind tdm_link_port tdm_link_port_assertions chk (.*);

// ===== testbench/tdm_link_port_tb.sv
module tdm_link_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, RESET, AWVALID, WVALID, BVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, ARREADY, RVALID;
    logic ck, sync, rxd;
    logic [tdm_pkg::AXI_AW-1:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, TX_BYTE, RX_BYTE, d;
    logic [31:0] lfsr = 32'hE92F825C;
    logic [3:0] WSTRB, TRANSMIT_FRAME_PULSE_OUT, TRANSMIT_FRAME_PULSE_OE_N;
    logic [3:0] TXD, TXD_OE_N, TX_BYTE_TAKEN, RX_BYTE_VALID;
    logic [1:0] BRESP, RRESP, r;
    logic [9:0] len = 10'h100;
    logic [15:0] v [8];
    logic [15:0] ctl [3] = '{16'h02A1, 16'h0281, 16'h02A5};
    logic [9:0] fl [3] = '{10'h100, 10'h0C1, 10'h200};
    int errors = 0;
    int check_count = 0;
    tdm_link_port dut (
        .*,
        .TRANSMIT_BIT_CLOCK({4{ck}}),
        .TRANSMIT_FRAME_PULSE_IN({4{sync}}),
        .RXCK({4{ck}}),
        .RXSYNC({4{sync}}),
        .RXD({4{rxd}})
    );
    tdm_framer_model model (.len(len), .txd(TXD[0]), .txd_oe_n(TXD_OE_N[0]), .ck(ck), .sync(sync), .rxd(rxd));
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : nx
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: %h vs %h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [13:0] a, input logic [15:0] x);
        logic aw = 1'b1;
        logic w = 1'b1;
        AWADDR <= a;
        WDATA <= {16'h0000, x};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while (aw || w)
        begin
            @(posedge CLK);
            aw = aw && !AWREADY;
            w = w && !WREADY;
            AWVALID <= aw;
            WVALID <= w;
        end
        do @(posedge CLK); while (!BVALID);
        cmp(BRESP, tdm_pkg::RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [13:0] a);
        ARADDR <= a;
        ARVALID <= 1'b1;
        do @(posedge CLK); while (!ARREADY);
        ARVALID <= 1'b0;
        do @(posedge CLK); while (!RVALID);
        d = RDATA;
        r = RRESP;
    endtask : rd
    task automatic wrap_up;
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial
    begin
        #450000;
        errors++;
        wrap_up();
    end
    initial
    begin
        RESET = 1'b1;
        {AWVALID, WVALID, ARVALID, BREADY, RREADY} = 5'h03;
        {AWADDR, ARADDR, WDATA, TX_BYTE, WSTRB} = '1;
        repeat (8) @(posedge CLK);
        RESET <= 1'b0;
        rd(14'h1800);
        cmp(d, {16'h0000, tdm_pkg::CTRL_RST});
        rd(14'h1FFC);
        cmp(d, 32'h00000000);
        cmp(r, tdm_pkg::RESP_SLVERR);
        for (int i = 0; i < 16; i++)
        begin
            lfsr = nx(lfsr);
            v[i % 8] = i < 8 ? lfsr[15:0] : v[i % 8];
            if (i < 8)
                wr((i > 3 ? 14'h1C40 : 14'h1840) + 14'(4 * (i % 4)), v[i]);
            else
                rd((i > 11 ? 14'h1C40 : 14'h1840) + 14'(4 * (i % 4)));
            if (i > 7)
                cmp(d, {16'h0000, v[i % 8]});
        end
        wr(14'h1840, 16'h0001);
        wr(14'h1844, 16'h0000);
        wr(14'h1C40, 16'h0001);
        wr(14'h1C44, 16'h0000);
        for (int m = 0; m < 3; m++)
        begin
            len <= fl[m];
            wr(14'h1800, ctl[m]);
            wr(14'h1C00, ctl[m] & 16'hFDFF);
            lfsr = nx(lfsr);
            TX_BYTE <= lfsr;
            repeat (2) do @(posedge CLK); while (!RX_BYTE_VALID[0]);
            cmp(RX_BYTE[7:0], lfsr[7:0]);
            cmp(TXD_OE_N[3:1], 3'h7);
            cmp(TRANSMIT_FRAME_PULSE_OE_N, 4'hF);
        end
        len <= 10'h100;
        wr(14'h1848, 16'h0002);
        wr(14'h184C, 16'h0000);
        wr(14'h1C48, 16'h0002);
        wr(14'h1C4C, 16'h0000);
        for (int k = 0; k < 4; k++)
            wr((k > 1 ? 14'h1C00 : 14'h1800) + 14'(4 * (k % 2)), k > 1 ? 16'h00A9 : 16'h02A9);
        lfsr = nx(lfsr);
        TX_BYTE <= lfsr;
        repeat (2) do @(posedge CLK); while (!RX_BYTE_VALID[1]);
        cmp(RX_BYTE[15:8], lfsr[15:8]);
        cmp(TXD_OE_N[3:1], 3'h7);
        wrap_up();
    end
endmodule : tdm_link_port_tb
